// ### logic/power_fault_cfg.svh
// Offsets, field positions, reset values and timing counts of the fault supervisor.
// Assumes a single 125 MHz system clock; included by the package and the modules.
`ifndef POWER_FAULT_CFG_SVH
`define POWER_FAULT_CFG_SVH

`define SYS_CLK_MHZ 125
`define OC_RESTART_MS 200
`define OC_RESTART_CYCLES (`OC_RESTART_MS * 1000 * `SYS_CLK_MHZ)
`define OC_RESTART_CNT_W 25

`define RAIL_MV_PER_LSB 100
`define TEMP_K_PER_LSB 5
`define TARGET_MV_PER_LSB 50
`define SENSE_MV_PER_LSB 5

`define CL_LIMIT_MSB 5
`define CL_LIMIT_LSB 0
`define CL_WARN_MSB 7
`define CL_WARN_LSB 6
`define CL_WARN_STEP_CODES 2

`define OT_WARN_NEAR_CODES 1
`define OT_WARN_FAR_CODES 2

`define OV_LOW_RANGE_MAX 8'h32
`define OV_LOW_BASE_CODES 3
`define OV_HIGH_SCALE 2

`define FLAG_UV_WARN_LSB 0
`define FLAG_UV_FAULT_LSB 2
`define FLAG_OT_WARN 4
`define FLAG_OT_FAULT 5
`define FLAG_OV_FAULT_LSB 8
`define FLAG_RESET 12'h000

`define GPIO_OC_WARN_LSB 4
`define GPIO_OC_FAULT_LSB 8

`endif

// ### logic/power_fault_pkg.sv
// Types shared by the fault supervisor and its restart timers.
// Assumes power_fault_cfg.svh for all field positions and counts.
`include "power_fault_cfg.svh"

package power_fault_pkg;
    typedef logic [7:0] rail_code_t;
    typedef logic [6:0] temp_code_t;
    typedef logic [7:0] target_code_t;
    typedef logic [8:0] vout_code_t;
    typedef logic [6:0] sense_code_t;
    typedef logic [13:0] target_mv_t;
    typedef logic [11:0] prot_flags_t;
    typedef enum logic [1:0] {
        CH_RUN = 2'b00,
        CH_OC_WAIT = 2'b01,
        CH_OV_OFF = 2'b10
    } chan_state_t;
endpackage

// ### logic/restart_timer_if.sv
// Start and expiry handshake between the supervisor and one restart timer.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
`default_nettype none

interface restart_timer_if;
    logic start;
    logic expired;
    modport ctrl (output start, input expired);
    modport timer (input start, output expired);
endinterface

`default_nettype wire

// ### logic/ocp_restart_timer.sv
// Over-current restart delay for one channel.
// Assumes start is a one-cycle pulse from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "power_fault_cfg.svh"

module ocp_restart_timer #(
    parameter int unsigned DELAY_CYCLES = `OC_RESTART_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst,
    restart_timer_if.timer tmr
);
    import power_fault_pkg::*;

    localparam logic [`OC_RESTART_CNT_W-1:0] LOAD = `OC_RESTART_CNT_W'(DELAY_CYCLES);
    logic [`OC_RESTART_CNT_W-1:0] count;

    // A new fault reloads the count, so the delay always runs from the latest trip.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            count <= '0;
            tmr.expired <= 1'b0;
        end else begin
            tmr.expired <= 1'b0;
            if (tmr.start) begin
                count <= LOAD;
            end else if (count != '0) begin
                count <= count - 1'b1;
                if (count == `OC_RESTART_CNT_W'(1)) begin
                    tmr.expired <= 1'b1;
                end
            end
        end
    end
endmodule

`default_nettype wire

// ### logic/power_fault_supervisor.sv
// Fault supervisor for a four-channel buck controller: input-low, thermal,
// over-voltage and over-current protection with follower propagation.
// Assumes converter samples arrive on sys_clk with a one-cycle sampleValid strobe.
// Contract
// - Flag each input rail at or below its warning level, 100mV steps, GPIO-mappable.
// - Flag each input rail at or below its own fault level, 100mV steps.
// - Input-low fault on either rail sets the fault flag and stops every channel.
// - Measured input rails are read back at 100mV per LSB.
// - Optionally restart once the rail rises above the warning level.
// - Junction temperature reads back in kelvin, 5K per LSB, 200K to 520K.
// - Overheat warning at 5 or 10 degrees below the fault threshold.
// - Overheat fault sets fault and warning bits, stops all channels, host link stays.
// - Overheat fault threshold is a 7-bit field at 5K per LSB.
// - Optionally restart after overheat once below a separate restart level.
// - Channel target voltage equals the target code times 50mV.
// - Each channel's measured output voltage is read back.
// - Over-voltage check always active; trip shuts channel, then sets its fault bit.
// - Over-voltage margin 150-300mV up to 2.5V targets, 300-600mV above.
// - Over-voltage also disables follower channels until the host re-enables them.
// - Any fault or warning can be routed to a general-purpose output pin.
// - Per-channel over-voltage mode: pulses stop, or low-side gate held on.
// - Current-limit register: bits 5:0 limit at 5mV, bits 7:6 warning offset.
// - Over-current warning within 10-40mV of limit, clears itself below it.
// - Over-current stops drivers, sets flag, restarts followers, soft-start after 200ms.
`timescale 1ns/1ps
`default_nettype none
`include "power_fault_cfg.svh"

module power_fault_supervisor #(
    parameter int unsigned OC_RESTART_CYCLES = `OC_RESTART_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic sampleValid,
    input wire power_fault_pkg::rail_code_t primaryInputRail,
    input wire power_fault_pkg::rail_code_t secondaryInputRail,
    input wire power_fault_pkg::rail_code_t [1:0] inputLowWarningLevel,
    input wire power_fault_pkg::rail_code_t [1:0] inputLowFaultLevel,
    input wire logic uvAutoRestart,
    input wire power_fault_pkg::temp_code_t junctionTemp,
    input wire power_fault_pkg::temp_code_t thermalShutdownThreshold,
    input wire power_fault_pkg::temp_code_t thermalRestartLevel,
    input wire logic otWarnFar,
    input wire logic otAutoRestart,
    input wire power_fault_pkg::target_code_t [3:0] channelTargetCode,
    input wire power_fault_pkg::vout_code_t [3:0] channelOutput,
    input wire logic [3:0][1:0] overvoltageThresholdSelect,
    input wire logic [3:0] ovForcedLow,
    input wire logic [7:0] followerMapLow,
    input wire logic [7:0] followerMapHigh,
    input wire logic [3:0][7:0] currentLimitAndWarning,
    input wire power_fault_pkg::sense_code_t [3:0] senseVoltage,
    input wire logic [3:0] hostEnable,
    input wire logic [3:0] hostReenable,
    input wire logic faultClear,
    input wire logic [3:0] gpioFlagSelect,
    output power_fault_pkg::rail_code_t primaryInputMeasure,
    output power_fault_pkg::rail_code_t secondaryInputMeasure,
    output power_fault_pkg::temp_code_t junctionTempMeasure,
    output power_fault_pkg::vout_code_t [3:0] channelOutputMeasure,
    output power_fault_pkg::target_mv_t [3:0] channelTargetMv,
    output power_fault_pkg::prot_flags_t protectionFlags,
    output logic [3:0] overcurrentWarningStatus,
    output logic [3:0] overcurrentFaultStatus,
    output logic [3:0] chanDrive,
    output logic [3:0] lowSideGate,
    output logic [3:0] softStartGo,
    output logic gpioFlag
);
    import power_fault_pkg::*;

    function automatic target_mv_t targetMv(input target_code_t code);
        targetMv = target_mv_t'(code) * target_mv_t'(`TARGET_MV_PER_LSB);
    endfunction

    // Margin in 50mV codes: 3..6 for low targets, doubled for high targets.
    function automatic logic [3:0] ovMargin(input target_code_t code, input logic [1:0] sel);
        logic [3:0] base;
        base = 4'(`OV_LOW_BASE_CODES) + {2'b00, sel};
        ovMargin = (code <= `OV_LOW_RANGE_MAX) ? base : 4'(base * `OV_HIGH_SCALE);
    endfunction

    function automatic sense_code_t ocWarnLevel(input logic [7:0] reg8);
        logic [6:0] limit;
        logic [6:0] offset;
        limit = {1'b0, reg8[`CL_LIMIT_MSB:`CL_LIMIT_LSB]};
        offset = 7'((reg8[`CL_WARN_MSB:`CL_WARN_LSB] + 3'd1) * `CL_WARN_STEP_CODES);
        ocWarnLevel = (limit > offset) ? (limit - offset) : 7'd0;
    endfunction

    function automatic logic [3:0] followersOf(input logic [3:0] trips, input logic [15:0] map);
        logic [3:0] hit;
        hit = 4'b0000;
        for (int j = 0; j < 4; j++) begin
            if (trips[j]) begin
                hit = hit | map[4*j +: 4];
            end
        end
        followersOf = hit;
    endfunction

    logic [1:0] uvWarn;
    logic [1:0] uvFault;
    logic otWarn;
    logic otFault;
    logic [3:0] ovFault;
    logic [3:0] ovTripSeen;
    chan_state_t [3:0] chanState;
    chan_state_t [3:0] next_chanState;
    logic [3:0] ovTrip;
    logic [3:0] ocTrip;
    logic [3:0] ovAny;
    logic [3:0] ocAny;
    logic [3:0] tmrExpired;
    logic [15:0] gpioVector;
    logic globalOff;
    logic next_otFault;
    rail_code_t [1:0] rails;
    temp_code_t otWarnPoint;

    assign rails = {secondaryInputRail, primaryInputRail};
    assign globalOff = (|uvFault) | otFault;

    // Readback registers follow the converter only on a new sample.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            primaryInputMeasure <= '0;
            secondaryInputMeasure <= '0;
            junctionTempMeasure <= '0;
            channelOutputMeasure <= '0;
        end else if (sampleValid) begin
            primaryInputMeasure <= primaryInputRail;
            secondaryInputMeasure <= secondaryInputRail;
            junctionTempMeasure <= junctionTemp;
            channelOutputMeasure <= channelOutput;
        end
    end

    // Input-low warning follows the rail; the fault latches, set beats any clear.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            uvWarn <= 2'b00;
            uvFault <= 2'b00;
        end else begin
            for (int r = 0; r < 2; r++) begin
                if (sampleValid) begin
                    uvWarn[r] <= rails[r] <= inputLowWarningLevel[r];
                end
                if (sampleValid && rails[r] <= inputLowFaultLevel[r]) begin
                    uvFault[r] <= 1'b1;
                end else if (faultClear ||
                             (sampleValid && uvAutoRestart &&
                              rails[r] > inputLowWarningLevel[r])) begin
                    uvFault[r] <= 1'b0;
                end
            end
        end
    end

    // Warning point saturates so a tiny threshold never wraps to a huge one.
    assign otWarnPoint = (thermalShutdownThreshold > 7'(`OT_WARN_FAR_CODES)) ?
        (thermalShutdownThreshold -
         (otWarnFar ? 7'(`OT_WARN_FAR_CODES) : 7'(`OT_WARN_NEAR_CODES))) : 7'd0;

    always_comb begin
        next_otFault = otFault;
        if (sampleValid && junctionTemp >= thermalShutdownThreshold) begin
            next_otFault = 1'b1;
        end else if (faultClear ||
                     (sampleValid && otAutoRestart && junctionTemp <= thermalRestartLevel)) begin
            next_otFault = 1'b0;
        end
    end

    // A standing overheat fault keeps the warning bit set as well.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            otFault <= 1'b0;
            otWarn <= 1'b0;
        end else begin
            otFault <= next_otFault;
            if (sampleValid) begin
                otWarn <= next_otFault || (junctionTemp >= otWarnPoint);
            end else begin
                otWarn <= otWarn | next_otFault;
            end
        end
    end

    // Over-voltage is checked in every state, soft-start included.
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            ovTrip[i] = sampleValid && (channelOutput[i] >
                vout_code_t'(channelTargetCode[i]) +
                vout_code_t'(ovMargin(channelTargetCode[i], overvoltageThresholdSelect[i])));
            ocTrip[i] = sampleValid && chanDrive[i] && (senseVoltage[i] >=
                {1'b0, currentLimitAndWarning[i][`CL_LIMIT_MSB:`CL_LIMIT_LSB]});
        end
    end

    assign ovAny = ovTrip | followersOf(ovTrip, {followerMapHigh, followerMapLow});
    assign ocAny = ocTrip | followersOf(ocTrip, {followerMapHigh, followerMapLow});

    // Over-voltage outranks a pending over-current restart.
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            next_chanState[i] = chanState[i];
            case (chanState[i])
                CH_RUN: begin
                    if (ovAny[i]) begin
                        next_chanState[i] = CH_OV_OFF;
                    end else if (ocAny[i]) begin
                        next_chanState[i] = CH_OC_WAIT;
                    end
                end
                CH_OC_WAIT: begin
                    if (ovAny[i]) begin
                        next_chanState[i] = CH_OV_OFF;
                    end else if (tmrExpired[i] && !ocAny[i]) begin
                        next_chanState[i] = CH_RUN;
                    end
                end
                CH_OV_OFF: begin
                    if (hostReenable[i]) begin
                        next_chanState[i] = CH_RUN;
                    end
                end
                default: begin
                    next_chanState[i] = CH_RUN;
                end
            endcase
        end
    end

    genvar g;
    restart_timer_if tmrIf[4] ();
    generate
        for (g = 0; g < 4; g++) begin : gen_timer
            assign tmrIf[g].start = ocAny[g] && !ovAny[g] && chanState[g] != CH_OV_OFF;
            assign tmrExpired[g] = tmrIf[g].expired;
            ocp_restart_timer #(
                .DELAY_CYCLES(OC_RESTART_CYCLES)
            ) u_timer (
                .sys_clk(sys_clk),
                .rst(rst),
                .tmr(tmrIf[g].timer)
            );
        end
    endgenerate

    // Drivers drop in the same edge as the state change; the flag follows a cycle later.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            chanState <= '{default: CH_RUN};
            chanDrive <= 4'b0000;
            lowSideGate <= 4'b0000;
            softStartGo <= 4'b0000;
        end else begin
            for (int i = 0; i < 4; i++) begin
                chanState[i] <= next_chanState[i];
                chanDrive[i] <= next_chanState[i] == CH_RUN && hostEnable[i] && !globalOff &&
                    !(sampleValid && (rails[0] <= inputLowFaultLevel[0] ||
                      rails[1] <= inputLowFaultLevel[1])) && !next_otFault;
                lowSideGate[i] <= next_chanState[i] == CH_OV_OFF && ovForcedLow[i];
                softStartGo[i] <= chanState[i] == CH_OC_WAIT && next_chanState[i] == CH_RUN;
            end
        end
    end

    // Fault bits latch; a trip in the clearing cycle still sets the bit.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ovTripSeen <= 4'b0000;
            ovFault <= 4'b0000;
            overcurrentFaultStatus <= 4'b0000;
            overcurrentWarningStatus <= 4'b0000;
        end else begin
            ovTripSeen <= ovTrip & ~{4{faultClear}} | ovTrip;
            for (int i = 0; i < 4; i++) begin
                if (ovTripSeen[i]) begin
                    ovFault[i] <= 1'b1;
                end else if (faultClear) begin
                    ovFault[i] <= 1'b0;
                end
                if (ocTrip[i]) begin
                    overcurrentFaultStatus[i] <= 1'b1;
                end else if (faultClear) begin
                    overcurrentFaultStatus[i] <= 1'b0;
                end
                if (sampleValid) begin
                    overcurrentWarningStatus[i] <= senseVoltage[i] >=
                        ocWarnLevel(currentLimitAndWarning[i]);
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            protectionFlags <= `FLAG_RESET;
        end else begin
            protectionFlags <= '0;
            protectionFlags[`FLAG_UV_WARN_LSB +: 2] <= uvWarn;
            protectionFlags[`FLAG_UV_FAULT_LSB +: 2] <= uvFault;
            protectionFlags[`FLAG_OT_WARN] <= otWarn;
            protectionFlags[`FLAG_OT_FAULT] <= otFault;
            protectionFlags[`FLAG_OV_FAULT_LSB +: 4] <= ovFault;
        end
    end

    always_comb begin
        gpioVector = {ovFault, overcurrentFaultStatus, overcurrentWarningStatus,
                      otFault, otWarn, uvFault[1] | uvFault[0], uvWarn[1] | uvWarn[0]};
    end

    // Hosts without the serial link watch one selected flag on a pin.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            gpioFlag <= 1'b0;
        end else begin
            gpioFlag <= gpioVector[gpioFlagSelect];
        end
    end

    // Target millivolts are derived for the regulation loop.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            channelTargetMv <= '0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                channelTargetMv[i] <= targetMv(channelTargetCode[i]);
            end
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence ovShutdown;
        chanState[0] == CH_OV_OFF && !chanDrive[0];
    endsequence

    sequence ovFlagged;
        ovFault[0] ##1 protectionFlags[`FLAG_OV_FAULT_LSB];
    endsequence

    a_uv_all_off: assert property ((|uvFault) |=> chanDrive == 4'b0000)
        else $error("channel driven during input-low fault");
    a_ot_both_bits: assert property (otFault |-> otWarn)
        else $error("overheat fault without warning bit");
    a_ov_trip_seq: assert property (ovTrip[0] |=> ovShutdown ##1 ovFlagged)
        else $error("over-voltage shutdown or flag out of order");
    a_ov_stays_off: assert property (chanState[0] == CH_OV_OFF && !hostReenable[0]
        |=> chanState[0] == CH_OV_OFF)
        else $error("over-voltage channel left off state without host");
    a_gate_only_ov: assert property (lowSideGate[0] |-> chanState[0] == CH_OV_OFF)
        else $error("low-side gate held outside over-voltage shutdown");
    a_oc_waits: assert property (ocTrip[0] && !ovAny[0] |=> chanState[0] == CH_OC_WAIT
        && !chanDrive[0])
        else $error("over-current did not stop channel");
    a_oc_restart: assert property (chanState[0] == CH_OC_WAIT && tmrExpired[0] && !ocAny[0]
        && !ovAny[0] |=> softStartGo[0] ##1 !softStartGo[0])
        else $error("soft-start pulse missing after restart delay");
    a_sample_hold: assert property (!sampleValid |=> $stable(junctionTempMeasure)
        && $stable(overcurrentWarningStatus))
        else $error("readback changed without a sample");
    a_oc_warn_set: assert property (sampleValid && senseVoltage[0] >=
        {1'b0, currentLimitAndWarning[0][`CL_LIMIT_MSB:`CL_LIMIT_LSB]}
        |=> overcurrentWarningStatus[0])
        else $error("warning missing at current limit");
endmodule

`default_nettype wire

// ### verif/sample_host.sv
// Converter sample pacer standing in for the far side of the supervisor.
// Assumes one system clock; pulses are launched 1 ns after the rising edge.
`timescale 1ns/1ps
`default_nettype none

module sample_host #(
    parameter int PERIOD = 4
) (
    input wire logic sys_clk,
    input wire logic rst,
    output logic sampleValid
);
    int cnt;
    initial begin
        sampleValid = 1'b0;
        cnt = 0;
    end
    // One-cycle strobe per sample, never two in a row, so flags move once per sample.
    always @(posedge sys_clk) begin
        #1;
        cnt = rst ? 0 : (cnt + 1) % PERIOD;
        sampleValid = !rst && cnt == 0;
    end
endmodule

`default_nettype wire

// ### verif/power_fault_supervisor_test.sv
// Self-checking bench for the fault supervisor.
// Assumes the sample pacer model and the design files compiled before it.
`timescale 1ns/1ps
`default_nettype none

module power_fault_supervisor_test;
    import power_fault_pkg::*;
    localparam int OCR = 20;
    logic sys_clk, rst, sampleValid, uvAutoRestart, otWarnFar, otAutoRestart, faultClear;
    rail_code_t primaryInputRail, secondaryInputRail, primaryInputMeasure, secondaryInputMeasure;
    rail_code_t [1:0] inputLowWarningLevel, inputLowFaultLevel;
    temp_code_t junctionTemp, thermalShutdownThreshold, thermalRestartLevel, junctionTempMeasure;
    target_code_t [3:0] channelTargetCode;
    vout_code_t [3:0] channelOutput, channelOutputMeasure;
    logic [3:0][1:0] overvoltageThresholdSelect;
    logic [3:0] ovForcedLow, hostEnable, hostReenable, gpioFlagSelect, softStartGo;
    logic [3:0] overcurrentWarningStatus, overcurrentFaultStatus, chanDrive, lowSideGate;
    logic [7:0] followerMapLow, followerMapHigh;
    logic [3:0][7:0] currentLimitAndWarning;
    sense_code_t [3:0] senseVoltage;
    target_mv_t [3:0] channelTargetMv;
    prot_flags_t protectionFlags;
    logic gpioFlag;
    int fails, totalChecks, thr, near, code, sel, m, lim, w, n;

    sample_host i_sample_host (.sys_clk(sys_clk), .rst(rst), .sampleValid(sampleValid));
    power_fault_supervisor #(.OC_RESTART_CYCLES(OCR)) i_power_fault_supervisor (
        .sys_clk(sys_clk), .rst(rst), .sampleValid(sampleValid),
        .primaryInputRail(primaryInputRail), .secondaryInputRail(secondaryInputRail),
        .inputLowWarningLevel(inputLowWarningLevel), .inputLowFaultLevel(inputLowFaultLevel),
        .uvAutoRestart(uvAutoRestart), .junctionTemp(junctionTemp),
        .thermalShutdownThreshold(thermalShutdownThreshold),
        .thermalRestartLevel(thermalRestartLevel), .otWarnFar(otWarnFar),
        .otAutoRestart(otAutoRestart), .channelTargetCode(channelTargetCode),
        .channelOutput(channelOutput), .overvoltageThresholdSelect(overvoltageThresholdSelect),
        .ovForcedLow(ovForcedLow), .followerMapLow(followerMapLow),
        .followerMapHigh(followerMapHigh), .currentLimitAndWarning(currentLimitAndWarning),
        .senseVoltage(senseVoltage), .hostEnable(hostEnable), .hostReenable(hostReenable),
        .faultClear(faultClear), .gpioFlagSelect(gpioFlagSelect),
        .primaryInputMeasure(primaryInputMeasure), .secondaryInputMeasure(secondaryInputMeasure),
        .junctionTempMeasure(junctionTempMeasure), .channelOutputMeasure(channelOutputMeasure),
        .channelTargetMv(channelTargetMv), .protectionFlags(protectionFlags),
        .overcurrentWarningStatus(overcurrentWarningStatus),
        .overcurrentFaultStatus(overcurrentFaultStatus), .chanDrive(chanDrive),
        .lowSideGate(lowSideGate), .softStartGo(softStartGo), .gpioFlag(gpioFlag));

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    function automatic int ovm(input int c, input int s);
        return (c <= 8'h32) ? 3 + s : (3 + s) * 2;
    endfunction

    task automatic step(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask

    // Twelve cycles span three samples, more than one sample wait plus the longest flag latency.
    task automatic settle;
        step(12);
    endtask

    task automatic chkv(input logic [15:0] g, input logic [15:0] e);
        totalChecks++;
        if (g !== e) begin
            fails++;
            $display("unexpected t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic giveVerdict;
        if (fails == 0 && totalChecks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic bound(input int k, input int top);
        if (k >= top) begin
            fails++;
            giveVerdict();
        end
    endtask

    task automatic pulse(input logic [3:0] re, input logic clr);
        hostReenable = re;
        faultClear = clr;
        step(1);
        hostReenable = 4'h0;
        faultClear = 1'b0;
        settle();
    endtask

    task automatic setRail(input int r, input logic [7:0] v);
        if (r == 1) secondaryInputRail = v;
        else primaryInputRail = v;
    endtask

    initial begin
        rst = 1'b1; hostEnable = 4'h0; hostReenable = 4'h0; faultClear = 1'b0;
        primaryInputRail = 8'h96; secondaryInputRail = 8'h96; uvAutoRestart = 1'b1;
        inputLowWarningLevel = {8'h64, 8'h64}; inputLowFaultLevel = {8'h50, 8'h50};
        junctionTemp = 7'h46; thermalShutdownThreshold = 7'h64; thermalRestartLevel = 7'h5a;
        otWarnFar = 1'b0; otAutoRestart = 1'b1; gpioFlagSelect = 4'h0;
        channelTargetCode = {4{8'h14}}; channelOutput = {4{9'h014}};
        overvoltageThresholdSelect = '0; ovForcedLow = 4'h0;
        followerMapLow = 8'h02; followerMapHigh = 8'h00;
        currentLimitAndWarning = {4{8'h3f}}; senseVoltage = '0;
        void'($urandom(37028));
        step(3);
        chkv(chanDrive, 4'h0); // [RESET]
        chkv(protectionFlags, 12'h000); // [RESET]
        rst = 1'b0;
        hostEnable = 4'hf;
        settle();
        chkv(chanDrive, 4'hf); // [RESET]
        for (int r = 0; r < 2; r++) begin
            setRail(r, 8'h64);
            settle();
            chkv(protectionFlags[3:0], 4'h1 << r);
            chkv(r ? secondaryInputMeasure : primaryInputMeasure, 8'h64);
            chkv(gpioFlag, 1'b1);
            setRail(r, 8'h50);
            settle();
            chkv(protectionFlags[3:0], 4'h5 << r);
            chkv(chanDrive, 4'h0);
            setRail(r, 8'h96);
            settle();
            chkv({protectionFlags[3:0], chanDrive}, 8'h0f);
        end
        for (int k = 0; k < 2; k++) begin
            thr = 40 + $urandom_range(60);
            otWarnFar = k;
            near = k + 1;
            thermalShutdownThreshold = thr;
            thermalRestartLevel = thr - 5;
            junctionTemp = thr - near - 1;
            settle();
            chkv(protectionFlags[5:4], 2'h0);
            chkv(junctionTempMeasure, thr - near - 1);
            junctionTemp = thr - near;
            settle();
            chkv(protectionFlags[5:4], 2'h1);
            junctionTemp = thr;
            settle();
            chkv({protectionFlags[5:4], chanDrive}, 6'h30);
            junctionTemp = thr - 5;
            settle();
            chkv({protectionFlags[5:4], chanDrive}, 6'h0f);
        end
        repeat (8) begin
            code = $urandom_range(102);
            if (code > 50) code = code & 8'hfe;
            channelTargetCode[3] = code;
            channelOutput[3] = code;
            settle();
            chkv(channelTargetMv[3], code * 50);
            chkv(channelOutputMeasure[3], code);
        end
        for (int k = 0; k < 2; k++) begin
            code = k ? 8'h40 : 8'h32;
            sel = $urandom_range(3);
            m = ovm(code, sel);
            overvoltageThresholdSelect[0] = sel;
            ovForcedLow[0] = k;
            channelTargetCode[0] = code;
            channelOutput[0] = code + m;
            settle();
            chkv(chanDrive, 4'hf);
            channelOutput[0] = code + m + 1;
            gpioFlagSelect = 4'hc;
            settle();
            chkv(chanDrive[1:0], 2'h0);
            chkv(lowSideGate[0], k);
            chkv(protectionFlags[11:8], 4'h1);
            chkv(gpioFlag, 1'b1);
            channelOutput[0] = code;
            settle();
            chkv(chanDrive[1:0], 2'h0);
            pulse(4'h3, 1'b0);
            chkv({chanDrive, lowSideGate}, 8'hf0);
            pulse(4'h0, 1'b1);
            chkv(protectionFlags[11:8], 4'h0);
        end
        // Restart timing is only reachable with the shortened delay parameter.
        sel = $urandom_range(3);
        lim = 20 + $urandom_range(20);
        w = (sel + 1) * 2;
        currentLimitAndWarning[0] = {sel[1:0], lim[5:0]};
        senseVoltage[0] = lim - w - 1;
        settle();
        chkv(overcurrentWarningStatus[0], 1'b0);
        senseVoltage[0] = lim - w;
        settle();
        chkv({overcurrentWarningStatus[0], overcurrentFaultStatus[0]}, 2'h2);
        senseVoltage[0] = lim;
        n = 0;
        while (overcurrentFaultStatus[0] !== 1'b1 && n < 20) begin
            step(1);
            n++;
        end
        bound(n, 20);
        senseVoltage[0] = 7'h00;
        chkv(chanDrive[1:0], 2'h0);
        n = 0;
        while (softStartGo[0] !== 1'b1 && n < 100) begin
            step(1);
            n++;
        end
        bound(n, 100);
        chkv(n, OCR + 1);
        chkv({softStartGo[1:0], chanDrive[1:0]}, 4'hf);
        pulse(4'h0, 1'b1);
        chkv({overcurrentWarningStatus[0], overcurrentFaultStatus[0]}, 2'h0);
        giveVerdict();
    end
endmodule

`default_nettype wire
